/* File: rtl/gpio_port.sv */
module gpio_port
  import gpio_pkg::*;
#(
  parameter int NPINS = GPIO_PINS
) (
  // Clock and reset
  input  logic              aclk,
  input  logic              aresetn,
  // AXI4-Lite write address
  input  logic              awvalid,
  output logic              awready,
  input  logic [ADDR_W-1:0] awaddr,
  input  logic [2:0]        awprot,
  // AXI4-Lite write data
  input  logic              wvalid,
  output logic              wready,
  input  logic [DATA_W-1:0] wdata,
  input  logic [3:0]        wstrb,
  // AXI4-Lite write response
  output logic              bvalid,
  input  logic              bready,
  output logic [1:0]        bresp,
  // AXI4-Lite read address
  input  logic              arvalid,
  output logic              arready,
  input  logic [ADDR_W-1:0] araddr,
  input  logic [2:0]        arprot,
  // AXI4-Lite read data
  output logic              rvalid,
  input  logic              rready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0]        rresp,
  // Pad inputs
  input  logic [NPINS-1:0]  pad_in_schmitt,
  input  logic [NPINS-1:0]  pad_in_ttl,
  // Pad outputs
  output logic [NPINS-1:0]  pad_out,
  output logic [NPINS-1:0]  pad_oe_n,
  output logic [NPINS-1:0]  pad_slew_limit,
  output logic [NPINS-1:0]  pad_ibuf_en,
  output logic [NPINS-1:0]  ana_connect,
  // Peripheral side
  input  logic [NPINS-1:0]  periph_out,
  output logic [NPINS-1:0]  periph_level
);

  // ==========================================================
  // Parameter check
  if (NPINS <= GPIO_INPUT_ONLY_PIN || NPINS > DATA_W) begin : g_bad_npins
    $error("gpio_port: NPINS out of range");
  end

  localparam logic [NPINS-1:0] IN_ONLY = NPINS'(1 << GPIO_INPUT_ONLY_PIN);
  localparam int LANE_BITS = 8;   // Data bits per write strobe

  if (LANE_BITS * $bits(wstrb) != DATA_W) begin : g_bad_lanes
    $error("gpio_port: strobe lanes do not cover the data bus");
  end

  // ==========================================================
  // Address map check
  // Decode compares whole words, so each offset must be aligned and unique
  localparam int NREGS = 10;
  localparam logic [ADDR_W-1:0] REG_MAP [NREGS] = '{
    A_PIN_VALUE, A_LATCH, A_DIR, A_ANSEL, A_ODRAIN,
    A_SLEW, A_THRESH, A_ROUTE, A_PV_SET, A_PV_CLR
  };

  for (genvar j = 0; j < NREGS; j++) begin : g_map
    if (REG_MAP[j][1:0] != 2'b00) begin : g_unaligned
      $error("gpio_port: register offset not word aligned");
    end
    for (genvar k = j + 1; k < NREGS; k++) begin : g_dup
      if (REG_MAP[j] == REG_MAP[k]) begin : g_shared
        $error("gpio_port: two registers share one offset");
      end
    end
  end

  // ==========================================================
  // State
  typedef struct packed {
    gpio_wr_st_t       wst;
    gpio_rd_st_t       rst;
    logic              aw_held;
    logic              w_held;
    logic [ADDR_W-1:0] waddr;
    logic [NPINS-1:0]  wbits;
    logic [NPINS-1:0]  wmask;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
    logic [NPINS-1:0]  lat;
    logic [NPINS-1:0]  dir;
    logic [NPINS-1:0]  ansel;
    logic [NPINS-1:0]  odrain;
    logic [NPINS-1:0]  slew;
    logic [NPINS-1:0]  thresh;
    logic [NPINS-1:0]  route;
  } gpio_state_t;

  localparam gpio_state_t ST_RST = '{
    wst:     WR_COLLECT,
    rst:     RD_IDLE,
    aw_held: 1'b0,
    w_held:  1'b0,
    waddr:   '0,
    wbits:   '0,
    wmask:   '0,
    awready: 1'b1,
    wready:  1'b1,
    bvalid:  1'b0,
    bresp:   RESP_OKAY,
    arready: 1'b1,
    rvalid:  1'b0,
    rdata:   '0,
    rresp:   RESP_OKAY,
    lat:     {NPINS{LAT_RST_BIT}},
    dir:     {NPINS{DIR_RST_BIT}},
    ansel:   {NPINS{ANSEL_RST_BIT}},
    odrain:  {NPINS{ODRAIN_RST_BIT}},
    slew:    {NPINS{SLEW_RST_BIT}},
    thresh:  {NPINS{THRESH_RST_BIT}},
    route:   {NPINS{ROUTE_RST_BIT}}
  };

  gpio_state_t       s_r;
  gpio_state_t       s_nxt;
  logic [NPINS-1:0]  level;
  logic [ADDR_W-1:0] wa;
  logic [ADDR_W-1:0] ra;
  logic              w_hit;
  logic              r_hit;
  logic [NPINS-1:0]  r_val;
  logic [NPINS-1:0]  lane_mask;

  // ==========================================================
  // Byte-lane merge
  // Wide ports would otherwise let one strobe overwrite every lane
  function automatic logic [NPINS-1:0] lane_merge(
    input logic [NPINS-1:0] old_bits,
    input logic [NPINS-1:0] new_bits,
    input logic [NPINS-1:0] mask
  );
    return (old_bits & ~mask) | (new_bits & mask);
  endfunction : lane_merge

  // ==========================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    wa    = {s_r.waddr[ADDR_W-1:2], 2'b00};
    ra    = {araddr[ADDR_W-1:2], 2'b00};
    w_hit = 1'b1;
    r_hit = 1'b1;
    r_val = '0;

    // Address and data may arrive in either order
    if (s_r.awready && awvalid) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.waddr   = awaddr;
    end
    if (s_r.wready && wvalid) begin
      s_nxt.w_held = 1'b1;
      s_nxt.wbits  = wdata[NPINS-1:0];
      s_nxt.wmask  = lane_mask;
    end

    case (s_r.wst)
      WR_COLLECT: begin
        if (s_r.aw_held && s_r.w_held) begin
          case (wa)
            A_PIN_VALUE: begin
              s_nxt.lat = lane_merge(s_r.lat, s_r.wbits, s_r.wmask);
            end
            A_LATCH: begin
              s_nxt.lat = lane_merge(s_r.lat, s_r.wbits, s_r.wmask);
            end
            A_DIR: begin
              s_nxt.dir = lane_merge(s_r.dir, s_r.wbits, s_r.wmask) | IN_ONLY;
            end
            A_ANSEL: begin
              s_nxt.ansel = lane_merge(s_r.ansel, s_r.wbits, s_r.wmask);
            end
            A_ODRAIN: begin
              s_nxt.odrain = lane_merge(s_r.odrain, s_r.wbits, s_r.wmask);
            end
            A_SLEW: begin
              s_nxt.slew = lane_merge(s_r.slew, s_r.wbits, s_r.wmask);
            end
            A_THRESH: begin
              s_nxt.thresh = lane_merge(s_r.thresh, s_r.wbits, s_r.wmask);
            end
            A_ROUTE: begin
              s_nxt.route = lane_merge(s_r.route, s_r.wbits, s_r.wmask);
            end
            // Analog pins sense zero, so a set/clear here can
            // unexpectedly clear their latch bits
            A_PV_SET: begin
              s_nxt.lat = lane_merge(s_r.lat, level | s_r.wbits, s_r.wmask);
            end
            A_PV_CLR: begin
              s_nxt.lat = lane_merge(s_r.lat, level & ~s_r.wbits, s_r.wmask);
            end
            default: begin
              w_hit = 1'b0;
            end
          endcase
          s_nxt.bresp   = w_hit ? RESP_OKAY : RESP_SLVERR;
          s_nxt.bvalid  = 1'b1;
          s_nxt.aw_held = 1'b0;
          s_nxt.w_held  = 1'b0;
          s_nxt.wst     = WR_RESP;
        end
      end
      WR_RESP: begin
        if (bready) begin
          s_nxt.bvalid = 1'b0;
          s_nxt.wst    = WR_COLLECT;
        end
      end
      default: begin
        s_nxt.wst = WR_COLLECT;
      end
    endcase

    // Hold off new requests until the response is taken
    s_nxt.awready = ~s_nxt.aw_held & (s_nxt.wst == WR_COLLECT);
    s_nxt.wready  = ~s_nxt.w_held & (s_nxt.wst == WR_COLLECT);

    case (ra)
      A_PIN_VALUE: r_val = level;
      A_LATCH:     r_val = s_r.lat;
      A_DIR:       r_val = s_r.dir | IN_ONLY;
      A_ANSEL:     r_val = s_r.ansel;
      A_ODRAIN:    r_val = s_r.odrain;
      A_SLEW:      r_val = s_r.slew;
      A_THRESH:    r_val = s_r.thresh;
      A_ROUTE:     r_val = s_r.route;
      A_PV_SET:    r_val = '0;
      A_PV_CLR:    r_val = '0;
      default:     r_hit = 1'b0;
    endcase

    case (s_r.rst)
      RD_IDLE: begin
        if (arvalid && s_r.arready) begin
          s_nxt.rdata              = '0;
          s_nxt.rdata[NPINS-1:0]   = r_val;
          s_nxt.rresp              = r_hit ? RESP_OKAY : RESP_SLVERR;
          s_nxt.rvalid             = 1'b1;
          s_nxt.rst                = RD_RESP;
        end
      end
      RD_RESP: begin
        if (rready) begin
          s_nxt.rvalid = 1'b0;
          s_nxt.rst    = RD_IDLE;
        end
      end
      default: begin
        s_nxt.rst = RD_IDLE;
      end
    endcase

    s_nxt.arready = (s_nxt.rst == RD_IDLE);
  end

  // ==========================================================
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign awready = s_r.awready;
  assign wready  = s_r.wready;
  assign bvalid  = s_r.bvalid;
  assign bresp   = s_r.bresp;
  assign arready = s_r.arready;
  assign rvalid  = s_r.rvalid;
  assign rdata   = s_r.rdata;
  assign rresp   = s_r.rresp;

  // ==========================================================
  // Pin cells
  for (genvar i = 0; i < NPINS; i++) begin : g_pin
    // Strobe of the byte lane that holds this pin
    assign lane_mask[i] = wstrb[i / LANE_BITS];

    gpio_out_cell #(
      .INPUT_ONLY (i == GPIO_INPUT_ONLY_PIN)
    ) u_out (
      .aclk           (aclk),
      .aresetn        (aresetn),
      .dir            (s_r.dir[i]),
      .lat            (s_r.lat[i]),
      .odrain         (s_r.odrain[i]),
      .slew           (s_r.slew[i]),
      .route          (s_r.route[i]),
      .periph_out     (periph_out[i]),
      .pad_out        (pad_out[i]),
      .pad_oe_n       (pad_oe_n[i]),
      .pad_slew_limit (pad_slew_limit[i])
    );

    gpio_in_cell u_in (
      .aclk           (aclk),
      .aresetn        (aresetn),
      .ansel          (s_r.ansel[i]),
      .thresh         (s_r.thresh[i]),
      .pad_in_schmitt (pad_in_schmitt[i]),
      .pad_in_ttl     (pad_in_ttl[i]),
      .level          (level[i]),
      .ibuf_en        (pad_ibuf_en[i]),
      .ana_connect    (ana_connect[i])
    );
  end

  // Sensed level is still offered to peripherals when one drives the pin
  assign periph_level = level;

endmodule : gpio_port

/* File: rtl/gpio_pkg.sv */
package gpio_pkg;

  // ==========================================================
  // Port geometry
  localparam int GPIO_PINS           = 6;
  localparam int GPIO_INPUT_ONLY_PIN = 3;

  // ==========================================================
  // Register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] A_PIN_VALUE = 8'h00;
  localparam logic [ADDR_W-1:0] A_LATCH     = 8'h04;
  localparam logic [ADDR_W-1:0] A_DIR       = 8'h08;
  localparam logic [ADDR_W-1:0] A_ANSEL     = 8'h0C;
  localparam logic [ADDR_W-1:0] A_ODRAIN    = 8'h10;
  localparam logic [ADDR_W-1:0] A_SLEW      = 8'h14;
  localparam logic [ADDR_W-1:0] A_THRESH    = 8'h18;
  localparam logic [ADDR_W-1:0] A_ROUTE     = 8'h1C;
  localparam logic [ADDR_W-1:0] A_PV_SET    = 8'h20;
  localparam logic [ADDR_W-1:0] A_PV_CLR    = 8'h24;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Per-bit reset values
  localparam logic DIR_RST_BIT    = 1'b1;
  localparam logic ANSEL_RST_BIT  = 1'b1;
  localparam logic LAT_RST_BIT    = 1'b0;
  localparam logic ODRAIN_RST_BIT = 1'b0;
  localparam logic SLEW_RST_BIT   = 1'b0;
  localparam logic THRESH_RST_BIT = 1'b1;
  localparam logic ROUTE_RST_BIT  = 1'b0;

  // ==========================================================
  // Channel states
  typedef enum logic {WR_COLLECT, WR_RESP} gpio_wr_st_t;
  typedef enum logic {RD_IDLE, RD_RESP} gpio_rd_st_t;

endpackage : gpio_pkg

/* File: rtl/gpio_out_cell.sv */
module gpio_out_cell
  import gpio_pkg::*;
#(
  parameter bit INPUT_ONLY = 1'b0
) (
  // Clock and reset
  input  logic aclk,
  input  logic aresetn,
  // Configuration
  input  logic dir,
  input  logic lat,
  input  logic odrain,
  input  logic slew,
  input  logic route,
  input  logic periph_out,
  // Pad side
  output logic pad_out,
  output logic pad_oe_n,
  output logic pad_slew_limit
);

  typedef struct packed {
    logic out;
    logic oe_n;
    logic slew;
  } gpio_oc_t;

  gpio_oc_t s_r;
  gpio_oc_t s_nxt;
  logic     drv_val;
  logic     drv_en;

  always_comb begin
    drv_val = route ? periph_out : lat;
    drv_en  = ~dir & ~INPUT_ONLY;
    s_nxt   = s_r;
    if (odrain) begin
      // Sink only: the pad is released for a one
      s_nxt.out  = 1'b0;
      s_nxt.oe_n = ~(drv_en & ~drv_val);
    end else begin
      s_nxt.out  = drv_val;
      s_nxt.oe_n = ~drv_en;
    end
    s_nxt.slew = slew;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '{out: 1'b0, oe_n: 1'b1, slew: SLEW_RST_BIT};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pad_out        = s_r.out;
  assign pad_oe_n       = s_r.oe_n;
  assign pad_slew_limit = s_r.slew;

endmodule : gpio_out_cell

/* File: rtl/gpio_in_cell.sv */
module gpio_in_cell
  import gpio_pkg::*;
(
  // Clock and reset
  input  logic aclk,
  input  logic aresetn,
  // Configuration
  input  logic ansel,
  input  logic thresh,
  // Pad comparators
  input  logic pad_in_schmitt,
  input  logic pad_in_ttl,
  // Results
  output logic level,
  output logic ibuf_en,
  output logic ana_connect
);

  typedef struct packed {
    logic level;
    logic ibuf_en;
    logic ana;
  } gpio_ic_t;

  gpio_ic_t s_r;
  gpio_ic_t s_nxt;

  always_comb begin
    s_nxt         = s_r;
    s_nxt.ibuf_en = ~ansel;
    // Threshold choice feeds both reads and peripheral edge logic
    s_nxt.level   = ansel ? 1'b0 :
                    (thresh ? pad_in_schmitt : pad_in_ttl);
    s_nxt.ana     = ansel;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '{level: 1'b0, ibuf_en: ~ANSEL_RST_BIT, ana: ANSEL_RST_BIT};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level       = s_r.level;
  assign ibuf_en     = s_r.ibuf_en;
  assign ana_connect = s_r.ana;

endmodule : gpio_in_cell

/* File: tb/gpio_pads.sv */
module gpio_pads
  import gpio_pkg::*;
(
  // Device side
  input  logic [GPIO_PINS-1:0] pad_out,
  input  logic [GPIO_PINS-1:0] pad_oe_n,
  // Board side
  input  logic [GPIO_PINS-1:0] ext_level,
  input  logic [GPIO_PINS-1:0] ttl_flip,
  // Comparators
  output logic [GPIO_PINS-1:0] pad_in_schmitt,
  output logic [GPIO_PINS-1:0] pad_in_ttl
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released pins follow the board; ttl_flip models a level between both thresholds
  assign pad_in_schmitt = (pad_out & ~pad_oe_n) | (ext_level & pad_oe_n);
  assign pad_in_ttl     = pad_in_schmitt ^ ttl_flip;
endmodule : gpio_pads

/* File: tb/gpio_port_asserts.sv */
module gpio_port_asserts
  import gpio_pkg::*;
#(
  parameter int NPINS = GPIO_PINS
) (
  // Clock and reset
  input logic             aclk,
  input logic             aresetn,
  // Register bus
  input logic             awvalid,
  input logic             awready,
  input logic             wvalid,
  input logic             wready,
  input logic             bvalid,
  input logic             bready,
  input logic             arvalid,
  input logic             arready,
  input logic             rvalid,
  input logic             rready,
  // Pads
  input logic [NPINS-1:0] pad_in_schmitt,
  input logic [NPINS-1:0] pad_in_ttl,
  input logic [NPINS-1:0] pad_oe_n,
  input logic [NPINS-1:0] pad_ibuf_en,
  input logic [NPINS-1:0] ana_connect,
  input logic [NPINS-1:0] periph_level
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ==========================================
  // Pins
  property p_pin3;
    pad_oe_n[GPIO_INPUT_ONLY_PIN];
  endproperty
  a_pin3: assert property (p_pin3) else $error("input-only pin driven");
  property p_ana;
    ana_connect == ~pad_ibuf_en;
  endproperty
  a_ana: assert property (p_ana) else $error("analog path mismatch");
  property p_zero;
    (periph_level & ~pad_ibuf_en) == '0;
  endproperty
  a_zero: assert property (p_zero) else $error("analog pin reads one");
  // Buffer enable changing in the same cycle is skipped to avoid alignment guesses
  property p_lvl;
    $stable(pad_ibuf_en) |-> ((periph_level ^ $past(pad_in_schmitt))
      & (periph_level ^ $past(pad_in_ttl)) & pad_ibuf_en) == '0;
  endproperty
  a_lvl: assert property (p_lvl) else $error("level not from pad");

  // ==========================================
  // Register bus
  property p_wr;
    awvalid && awready && wvalid && wready |=> !awready && !wready && !bvalid ##1 bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("write timing");
  property p_bdone;
    bvalid && bready |=> !bvalid && awready && wready;
  endproperty
  a_bdone: assert property (p_bdone) else $error("write not closed");
  property p_rd;
    arvalid && arready |=> rvalid && !arready;
  endproperty
  a_rd: assert property (p_rd) else $error("read timing");
  property p_rdone;
    rvalid && rready |=> !rvalid && arready;
  endproperty
  a_rdone: assert property (p_rdone) else $error("read not closed");

  c_wr: cover property (bvalid && bready);
  c_drv: cover property (pad_oe_n != '1);
  c_dig: cover property (pad_ibuf_en == '1);
endmodule : gpio_port_asserts

bind gpio_port gpio_port_asserts #(.NPINS(NPINS)) u_asserts (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
  .pad_in_schmitt(pad_in_schmitt), .pad_in_ttl(pad_in_ttl), .pad_oe_n(pad_oe_n),
  .pad_ibuf_en(pad_ibuf_en), .ana_connect(ana_connect), .periph_level(periph_level)
);

/* File: tb/tb.sv */
module tb
  import gpio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0] wa;
    logic [5:0] wd;
    logic [7:0] ra;
    logic [5:0] rx;
    logic [5:0] ox;
    logic [5:0] sx;
  } gpio_row_t;

  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, data;
  logic [1:0]  bresp, rresp, resp;
  logic [5:0]  schm, ttl, pad_out, pad_oe_n, slew, ibuf, ana, plev, periph, ext, flip;
  int          mismatches, num_checks;
  gpio_row_t   rows [13];

  gpio_port dut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .pad_in_schmitt(schm), .pad_in_ttl(ttl), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .pad_slew_limit(slew), .pad_ibuf_en(ibuf), .ana_connect(ana),
    .periph_out(periph), .periph_level(plev)
  );

  gpio_pads u_pads (
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .ext_level(ext), .ttl_flip(flip),
    .pad_in_schmitt(schm), .pad_in_ttl(ttl)
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ==========================================
  // Tasks
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic tmo(input bit expired);
    if (expired) begin
      mismatches++;
      results();
    end
  endtask : tmo

  // Ready lines stay high, so each task leaves a clean edge for the next one
  task automatic wr(input logic [7:0] a, input logic [5:0] d, output logic [1:0] r);
    int n;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    awaddr  <= a;
    wdata   <= 32'(d);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 40);
    r = bresp;
    tmo(!bvalid);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    arvalid <= 1'b1;
    araddr  <= a;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 40);
    d = rdata;
    r = rresp;
    tmo(!rvalid);
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [5:0] e);
    rd(a, data, resp);
    chk("rdata", 32'(e), data);
  endtask : rchk

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("pad_oe_n", 32'h3F, 32'(pad_oe_n));
    chk("ana_connect", 32'h3F, 32'(ana));
    chk("pad_ibuf_en", 32'h00, 32'(ibuf));
    rchk(A_DIR, 6'h3F);
    rchk(A_ANSEL, 6'h3F);
    rchk(A_THRESH, 6'h3F);
    rchk(A_ROUTE, 6'h00);
    $display("reset test done");
  endtask : do_reset

  // ==========================================
  // Main sequence
  initial begin
    {awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    {bready, rready} = 2'b11;
    periph = 6'h15;
    ext    = 6'h0C;
    flip   = 6'h01;
    rows = '{
      '{A_ANSEL,  6'h00, A_ANSEL,     6'h00, 6'h3F, 6'h00},
      '{A_LATCH,  6'h2D, A_PIN_VALUE, 6'h0C, 6'h3F, 6'h00},
      '{A_DIR,    6'h00, A_DIR,       6'h08, 6'h08, 6'h00},
      '{A_PIN_VALUE, 6'h12, A_LATCH,  6'h12, 6'h08, 6'h00},
      '{A_THRESH, 6'h3E, A_PIN_VALUE, 6'h1B, 6'h08, 6'h00},
      '{A_ODRAIN, 6'h3F, A_ODRAIN,    6'h3F, 6'h1A, 6'h00},
      '{A_ODRAIN, 6'h00, A_PV_SET,    6'h00, 6'h08, 6'h00},
      '{A_SLEW,   6'h15, A_SLEW,      6'h15, 6'h08, 6'h15},
      '{A_PV_SET, 6'h01, A_LATCH,     6'h1B, 6'h08, 6'h15},
      '{A_PV_CLR, 6'h02, A_LATCH,     6'h18, 6'h08, 6'h15},
      '{A_ANSEL,  6'h3F, A_PIN_VALUE, 6'h00, 6'h08, 6'h15},
      '{A_ANSEL,  6'h00, A_ANSEL,     6'h00, 6'h08, 6'h15},
      '{A_ROUTE,  6'h37, A_PIN_VALUE, 6'h1C, 6'h08, 6'h15}
    };
    do_reset();
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd, resp);
      chk("bresp", 32'(RESP_OKAY), 32'(resp));
      repeat (3) @(posedge aclk);
      rchk(rows[i].ra, rows[i].rx);
      chk("pad_oe_n", 32'(rows[i].ox), 32'(pad_oe_n));
      chk("slew", 32'(rows[i].sx), 32'(slew));
      $display("row %0d done", i);
    end
    chk("drive", 32'h15, 32'(pad_out & ~pad_oe_n));
    chk("pad_ibuf_en", 32'h3F, 32'(ibuf));
    chk("ana_connect", 32'h00, 32'(ana));
    wr(A_ROUTE, 6'h00, resp);
    repeat (3) @(posedge aclk);
    chk("drive", 32'h10, 32'(pad_out & ~pad_oe_n));
    $display("route test done");
    // Unmapped access must not disturb the latch
    wr(8'h40, 6'h3F, resp);
    chk("bresp", 32'(RESP_SLVERR), 32'(resp));
    rd(8'h40, data, resp);
    chk("rresp", 32'(RESP_SLVERR), 32'(resp));
    chk("rdata", 32'h0, data);
    rchk(A_LATCH, 6'h18);
    $display("unmapped test done");
    do_reset();
    results();
  end
endmodule : tb
